/* hdl/ssr_receiver.sv */
`timescale 1ns/1ps
module ssr_receiver (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial pins
   input  wire logic        shift_clock_pin_i,
   output logic             shift_clock_pin_o,
   output logic             shift_clock_pin_oe,
   input  wire logic        serial_data_pin_i,
   output logic             serial_data_pin_o,
   output logic             serial_data_pin_oe,
   // Processor side
   output logic             wake_request,
   output logic             vector_branch
);
   logic       rst_s1_q, rst_s2_q, rstn;
   logic [7:0] rsc_q, tsc_q, pol_q, icr_q;
   logic       rie_q, flag_q, sleep_q, wake_q, ovr_q;
   logic       ck_s1_q, ck_s2_q, ck_d_q, dt_s1_q, dt_s2_q;
   logic [3:0] cnt_q;
   logic [8:0] sh_q;
   ssr_pkg::ssr_state_t st_q;
   ssr_pkg::ssr_word_t  buf_q [2];
   logic [1:0] cnt_buf_q;
   logic       wp_q, rp_q;
   logic       slave_en, rcv_en, ck_act, ck_prev, edge_act, dt_in;
   logic       word_done, buf_push, buf_ready, buf_pop, apb_acc, apb_wr, apb_rd;
   logic [3:0] word_len;

   // Reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rstn = rst_s2_q;

   // Pins are inputs only; no shift clock is generated
   assign shift_clock_pin_o  = 1'b0;
   assign shift_clock_pin_oe = 1'b0;
   assign serial_data_pin_o  = 1'b0;
   assign serial_data_pin_oe = 1'b0;

   assign apb_acc = psel && penable;
   assign apb_wr  = apb_acc && pwrite;
   assign apb_rd  = apb_acc && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Mode decode
   assign slave_en = rsc_q[ssr_pkg::RSC_PORT_EN_BIT] && tsc_q[ssr_pkg::TSC_SYNC_BIT]
                     && !tsc_q[ssr_pkg::TSC_CLK_SRC_BIT];
   assign rcv_en   = slave_en && rsc_q[ssr_pkg::RSC_CONT_RX_BIT];
   assign word_len = rsc_q[ssr_pkg::RSC_NINE_SEL_BIT] ? ssr_pkg::NINE_BITS : ssr_pkg::EIGHT_BITS;

   // Pin synchronisers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_d_q  <= 1'b0;
         dt_s1_q <= 1'b0;
         dt_s2_q <= 1'b0;
      end else if (clk_en) begin
         ck_s1_q <= shift_clock_pin_i;
         ck_s2_q <= ck_s1_q;
         ck_d_q  <= ck_s2_q;
         dt_s1_q <= serial_data_pin_i;
         dt_s2_q <= dt_s1_q;
      end
   end
   assign ck_act   = ck_s2_q ^ pol_q[ssr_pkg::POL_CLK_BIT];
   assign ck_prev  = ck_d_q ^ pol_q[ssr_pkg::POL_CLK_BIT];
   assign edge_act = ck_act && !ck_prev;
   assign dt_in    = dt_s2_q ^ pol_q[ssr_pkg::POL_DATA_BIT];

   // Shift state machine
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q  <= ssr_pkg::SSR_IDLE;
         cnt_q <= 4'h0;
         sh_q  <= 9'h000;
      end else if (clk_en) begin
         case (st_q)
            ssr_pkg::SSR_IDLE: begin
               cnt_q <= 4'h0;
               if (rcv_en && edge_act) begin
                  sh_q  <= {dt_in, 8'h00};
                  cnt_q <= 4'h1;
                  st_q  <= ssr_pkg::SSR_SHIFT;
               end
            end
            ssr_pkg::SSR_SHIFT: begin
               if (!rcv_en) begin
                  st_q <= ssr_pkg::SSR_IDLE;
               end else if (cnt_q == word_len) begin
                  st_q <= ssr_pkg::SSR_DONE;
               end else if (edge_act) begin
                  sh_q  <= {dt_in, sh_q[8:1]};
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            ssr_pkg::SSR_DONE: begin
               st_q <= ssr_pkg::SSR_IDLE;
            end
            default: st_q <= ssr_pkg::SSR_IDLE;
         endcase
      end
   end
   assign word_done = (st_q == ssr_pkg::SSR_DONE);

   // Two-entry receive buffer; a full buffer on a new word is an overrun
   assign buf_push  = word_done && buf_ready;
   assign buf_ready = (cnt_buf_q != 2'd2);
   assign buf_pop   = apb_rd && (paddr == ssr_pkg::RECEIVE_BUFFER_OFF) && (cnt_buf_q != 2'd0);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_q      <= 1'b0;
         rp_q      <= 1'b0;
         cnt_buf_q <= 2'd0;
         buf_q[0]  <= '0;
         buf_q[1]  <= '0;
      end else if (clk_en) begin
         if (buf_push) begin
            buf_q[wp_q].data <= (word_len == ssr_pkg::NINE_BITS) ? sh_q : {1'b0, sh_q[8:1]};
            wp_q             <= ~wp_q;
         end
         if (buf_pop) begin
            rp_q <= ~rp_q;
         end
         cnt_buf_q <= cnt_buf_q + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // Overrun error, cleared by dropping continuous receive
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ovr_q <= 1'b0;
      end else if (clk_en) begin
         if (word_done && !buf_ready) begin
            ovr_q <= 1'b1;
         end else if (!rsc_q[ssr_pkg::RSC_CONT_RX_BIT]) begin
            ovr_q <= 1'b0;
         end
      end
   end

   // Complete flag follows buffer occupancy, set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_q <= 1'b0;
      end else if (clk_en) begin
         flag_q <= buf_push || (cnt_buf_q + {1'b0, buf_push} - {1'b0, buf_pop} != 2'd0);
      end
   end

   // Control registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsc_q <= ssr_pkg::RESET_BYTE;
         tsc_q <= ssr_pkg::RESET_BYTE;
         pol_q <= ssr_pkg::RESET_BYTE;
         icr_q <= ssr_pkg::RESET_BYTE;
         rie_q <= 1'b0;
      end else if (clk_en && apb_wr) begin
         case (paddr)
            ssr_pkg::RCV_STATUS_CONTROL_OFF: rsc_q <= {pwdata[7:4], 4'h0};
            ssr_pkg::XMT_STATUS_CONTROL_OFF: tsc_q <= pwdata[7:0];
            ssr_pkg::POLARITY_CONTROL_OFF:   pol_q <= pwdata[7:0];
            ssr_pkg::INTERRUPT_CONTROL_OFF:  icr_q <= pwdata[7:0];
            ssr_pkg::PERIPH_INT_ENABLE_OFF:  rie_q <= pwdata[ssr_pkg::PIE_ENABLE_BIT];
            default: ;
         endcase
      end
   end

   // Low-power state and wake
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sleep_q <= 1'b0;
         wake_q  <= 1'b0;
      end else if (clk_en) begin
         if (sleep_q && flag_q && rie_q) begin
            sleep_q <= 1'b0;
            wake_q  <= 1'b1;
         end else if (apb_wr && paddr == ssr_pkg::POWER_CONTROL_OFF) begin
            sleep_q <= pwdata[ssr_pkg::PWR_SLEEP_BIT];
            wake_q  <= 1'b0;
         end
      end
   end

   // Processor-side outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_request  <= 1'b0;
         vector_branch <= 1'b0;
      end else if (clk_en) begin
         wake_request  <= wake_q;
         vector_branch <= flag_q && rie_q && icr_q[ssr_pkg::ICR_GLOBAL_BIT]
                          && icr_q[ssr_pkg::ICR_PERIPH_BIT];
      end
   end

   // Read mux, ninth bit and error shown in status
   always_comb begin
      prdata = 32'h0000_0000;
      if (apb_rd) begin
         case (paddr)
            ssr_pkg::RCV_STATUS_CONTROL_OFF: prdata[7:0] = {rsc_q[7:4], 2'b00, ovr_q,
                                                            buf_q[rp_q].data[8]};
            ssr_pkg::RECEIVE_BUFFER_OFF:     prdata[7:0] = buf_q[rp_q].data[7:0];
            ssr_pkg::XMT_STATUS_CONTROL_OFF: prdata[7:0] = tsc_q;
            ssr_pkg::POLARITY_CONTROL_OFF:   prdata[7:0] = pol_q;
            ssr_pkg::INTERRUPT_CONTROL_OFF:  prdata[7:0] = icr_q;
            ssr_pkg::PERIPH_INT_ENABLE_OFF:  prdata[1:0] = {flag_q, rie_q};
            ssr_pkg::POWER_CONTROL_OFF:      prdata[1:0] = {wake_q, sleep_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // Checks
   sequence s_word_end;
      clk_en && st_q == ssr_pkg::SSR_DONE && buf_ready;
   endsequence
   sequence s_last_bit;
      clk_en && st_q == ssr_pkg::SSR_SHIFT && rcv_en && cnt_q == word_len;
   endsequence
   sequence s_bit_in;
      clk_en && st_q == ssr_pkg::SSR_SHIFT && rcv_en && cnt_q != word_len && edge_act;
   endsequence

   AST_PUSH_FLAG: assert property (@(posedge clk) disable iff (!rstn)
      s_word_end |=> flag_q) else $error("flag not set after word");
   AST_NO_RX_WHEN_OFF: assert property (@(posedge clk) disable iff (!rstn)
      !rcv_en && st_q == ssr_pkg::SSR_IDLE |=> st_q != ssr_pkg::SSR_DONE) else $error("received while off");
   AST_MODE: assert property (@(posedge clk) disable iff (!rstn)
      tsc_q[ssr_pkg::TSC_CLK_SRC_BIT] |-> !rcv_en) else $error("master mode receiving");
   AST_ERR_CLR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && !rsc_q[ssr_pkg::RSC_CONT_RX_BIT] && !word_done |=> !ovr_q) else $error("error not cleared");
   AST_VEC: assert property (@(posedge clk) disable iff (!rstn)
      vector_branch |-> $past(icr_q[ssr_pkg::ICR_GLOBAL_BIT] && icr_q[ssr_pkg::ICR_PERIPH_BIT]))
      else $error("vector without enables");
   AST_WAKE: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && sleep_q && flag_q && rie_q |=> wake_q && !sleep_q) else $error("no wake");
   AST_NO_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
      !shift_clock_pin_oe) else $error("clock pin driven");
   AST_BUF_STORE: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && buf_push |=> cnt_buf_q != 2'd0) else $error("word not stored");
   AST_START: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && st_q == ssr_pkg::SSR_IDLE && rcv_en && edge_act
      |=> st_q == ssr_pkg::SSR_SHIFT && cnt_q == 4'h1 && sh_q[8] == $past(dt_in)) else $error("first bit not taken");
   AST_LSB_FIRST: assert property (@(posedge clk) disable iff (!rstn)
      s_bit_in |=> sh_q[8] == $past(dt_in) && cnt_q == $past(cnt_q) + 4'h1)
      else $error("bit not shifted in");
   AST_WORD_END: assert property (@(posedge clk) disable iff (!rstn)
      s_last_bit |=> st_q == ssr_pkg::SSR_DONE) else $error("word length not kept");
   AST_ABORT: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && st_q == ssr_pkg::SSR_SHIFT && !rcv_en |=> st_q == ssr_pkg::SSR_IDLE) else $error("word not aborted");
   AST_OVR_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && word_done && !buf_ready |=> ovr_q) else $error("overrun not flagged");
   AST_VEC_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && flag_q && rie_q && icr_q[ssr_pkg::ICR_GLOBAL_BIT] && icr_q[ssr_pkg::ICR_PERIPH_BIT]
      |=> vector_branch) else $error("vector not raised");
   AST_FLAG_CLR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && cnt_buf_q == 2'h1 && buf_pop && !buf_push |=> !flag_q) else $error("flag not cleared");
   AST_BUF_LIMIT: assert property (@(posedge clk) disable iff (!rstn)
      cnt_buf_q != 2'h3) else $error("buffer count out of range");
   AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && wake_q && !(apb_wr && paddr == ssr_pkg::POWER_CONTROL_OFF) |=> wake_q)
      else $error("wake lost");
endmodule

/* hdl/ssr_pkg.sv */
package ssr_pkg;
   // Register byte offsets
   localparam logic [7:0] RCV_STATUS_CONTROL_OFF   = 8'h00;
   localparam logic [7:0] RECEIVE_BUFFER_OFF       = 8'h04;
   localparam logic [7:0] XMT_STATUS_CONTROL_OFF   = 8'h08;
   localparam logic [7:0] POLARITY_CONTROL_OFF     = 8'h0c;
   localparam logic [7:0] INTERRUPT_CONTROL_OFF    = 8'h10;
   localparam logic [7:0] PERIPH_INT_ENABLE_OFF    = 8'h14;
   localparam logic [7:0] POWER_CONTROL_OFF        = 8'h18;
   // Receive status/control fields
   localparam int RSC_PORT_EN_BIT   = 7;
   localparam int RSC_NINE_SEL_BIT  = 6;
   localparam int RSC_SINGLE_RX_BIT = 5;
   localparam int RSC_CONT_RX_BIT   = 4;
   localparam int RSC_OVR_BIT   = 1;
   localparam int RSC_NINTH_BIT = 0;
   // Transmit status/control fields
   localparam int TSC_CLK_SRC_BIT = 7;
   localparam int TSC_SYNC_BIT  = 4;
   // Polarity fields
   localparam int POL_DATA_BIT  = 5;
   localparam int POL_CLK_BIT   = 4;
   // Interrupt control fields
   localparam int ICR_GLOBAL_BIT = 7;
   localparam int ICR_PERIPH_BIT = 6;
   // Peripheral flag/enable register fields
   localparam int PIE_ENABLE_BIT = 0;
   localparam int PIE_FLAG_BIT   = 1;
   // Power control: bit0 sleep/idle request, bit1 wake pending
   localparam int PWR_SLEEP_BIT = 0;
   localparam int PWR_WAKE_BIT  = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] NINE_BITS  = 4'h9;
   localparam logic [3:0] EIGHT_BITS = 4'h8;

   typedef struct packed {
      logic [8:0] data;
   } ssr_word_t;

   typedef enum logic [1:0] {
      SSR_IDLE  = 2'b00,
      SSR_SHIFT = 2'b01,
      SSR_DONE  = 2'b10
   } ssr_state_t;
endpackage

/* test/ssr_master_model.sv */
`timescale 1ns/1ps
module ssr_master_model (
   // Bench clock
   input  wire logic clk,
   // Link pins
   output logic      shift_clock_o,
   output logic      serial_data_o
);
   initial begin
      shift_clock_o = 1'b0;
      serial_data_o = 1'b0;
   end
   // Park the clock at its idle level before polarity changes
   task automatic idle(input logic cp);
      @(posedge clk);
      shift_clock_o <= cp;
      repeat (2) @(posedge clk);
   endtask
   // One frame of 400 ns bit periods; the clock stands still outside it
   task automatic send(input logic [8:0] w, input int n, input logic cp, input logic dp);
      @(posedge clk);
      shift_clock_o <= cp;
      for (int i = 0; i < n; i++) begin
         serial_data_o <= w[i] ^ dp; // LSB first, optional inversion
         repeat (4) @(posedge clk);
         shift_clock_o <= ~cp; // Clock supplied by the master, active edge
         repeat (4) @(posedge clk);
         shift_clock_o <= cp;
      end
      repeat (4) @(posedge clk);
      serial_data_o <= ~serial_data_o; // Released line shows no stale value
   endtask
endmodule

/* test/sync_slave_serial_receiver_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module sync_slave_serial_receiver_test;
   typedef struct {logic [8:0] w; logic nine, cp, dp; logic [7:0] lo; logic nb;} ssr_row_t;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready;
   logic        pslverr;
   logic        sck_oe;
   logic        sd_oe;
   logic        sck;
   logic        sd;
   logic        wake_request;
   logic        vector_branch;
   int          miscompares = 0;
   int          tests_run   = 0;
   ssr_row_t    rows [5] = '{'{9'h0a5, 1'b0, 1'b0, 1'b0, 8'ha5, 1'b0}, '{9'h13c, 1'b1, 1'b0, 1'b0, 8'h3c, 1'b1},
      '{9'h081, 1'b0, 1'b1, 1'b0, 8'h81, 1'b0}, '{9'h0fe, 1'b1, 1'b1, 1'b1, 8'hfe, 1'b0},
      '{9'h1c3, 1'b1, 1'b0, 1'b1, 8'hc3, 1'b1}};
   always #25 clk = ~clk;
   ssr_master_model m (.clk(clk), .shift_clock_o(sck), .serial_data_o(sd));
   ssr_receiver dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shift_clock_pin_i(sck), .shift_clock_pin_o(), .shift_clock_pin_oe(sck_oe), .serial_data_pin_i(sd),
      .serial_data_pin_o(), .serial_data_pin_oe(sd_oe), .wake_request(wake_request), .vector_branch(vector_branch));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] rxc, input logic [31:0] txc, input logic cp, input logic dp);
      apb(1'b1, ssr_pkg::RCV_STATUS_CONTROL_OFF, 32'h80);
      apb(1'b1, ssr_pkg::XMT_STATUS_CONTROL_OFF, txc);
      m.idle(cp);
      apb(1'b1, ssr_pkg::POLARITY_CONTROL_OFF, {26'h0, dp, cp, 4'h0});
      apb(1'b1, ssr_pkg::PERIPH_INT_ENABLE_OFF, 32'h1);
      apb(1'b1, ssr_pkg::INTERRUPT_CONTROL_OFF, 32'hc0);
      apb(1'b1, ssr_pkg::RCV_STATUS_CONTROL_OFF, rxc);
   endtask
   task automatic wait_flag();
      r = 32'h0;
      for (int i = 0; i < 40 && r[1] !== 1'b1; i++) apb(1'b0, ssr_pkg::PERIPH_INT_ENABLE_OFF, 32'h0);
   endtask
   task automatic quiet_word(input logic [31:0] rxc, input logic [31:0] txc);
      cfg(rxc, txc, 1'b0, 1'b0);
      m.send(9'h0ff, 8, 1'b0, 1'b0);
      repeat (10) @(posedge clk);
      apb(1'b0, ssr_pkg::PERIPH_INT_ENABLE_OFF, 32'h0);
   endtask
   task automatic wrap_up();
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #2000000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, ssr_pkg::RCV_STATUS_CONTROL_OFF, 32'h0);
      `CHK(r, 32'h0)
      `CHK({wake_request, vector_branch}, 2'b00)
      `CHK({pslverr, sck_oe, sd_oe}, 3'h0)
      $display("test reset done");
      foreach (rows[i]) begin
         cfg({24'h0, 1'b1, rows[i].nine, 2'b01, 4'h0}, 32'h10, rows[i].cp, rows[i].dp);
         m.send(rows[i].w, rows[i].nine ? 9 : 8, rows[i].cp, rows[i].dp);
         wait_flag();
         `CHK(r[1], 1'b1)
         apb(1'b0, ssr_pkg::RCV_STATUS_CONTROL_OFF, 32'h0);
         `CHK(r[1:0], {1'b0, rows[i].nb})
         `CHK(vector_branch, 1'b1)
         apb(1'b0, ssr_pkg::RECEIVE_BUFFER_OFF, 32'h0);
         `CHK(r[7:0], rows[i].lo)
         apb(1'b0, ssr_pkg::PERIPH_INT_ENABLE_OFF, 32'h0);
         `CHK(r[1], 1'b0)
         $display("test row %0d done", i);
      end
      cfg(32'h90, 32'h10, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++) m.send(9'h011 << k, 8, 1'b0, 1'b0);
      wait_flag();
      apb(1'b0, ssr_pkg::RCV_STATUS_CONTROL_OFF, 32'h0);
      `CHK(r[1], 1'b1)
      apb(1'b0, ssr_pkg::RECEIVE_BUFFER_OFF, 32'h0);
      `CHK(r[7:0], 8'h11)
      apb(1'b0, ssr_pkg::RECEIVE_BUFFER_OFF, 32'h0);
      `CHK(r[7:0], 8'h22)
      apb(1'b1, ssr_pkg::RCV_STATUS_CONTROL_OFF, 32'h80);
      apb(1'b0, ssr_pkg::RCV_STATUS_CONTROL_OFF, 32'h0);
      `CHK(r[1], 1'b0)
      $display("test overrun done");
      cfg(32'h90, 32'h10, 1'b0, 1'b0);
      apb(1'b1, ssr_pkg::INTERRUPT_CONTROL_OFF, 32'h80);
      apb(1'b1, ssr_pkg::POWER_CONTROL_OFF, 32'h1);
      m.send(9'h05a, 8, 1'b0, 1'b0);
      wait_flag();
      `CHK(vector_branch, 1'b0)
      `CHK(wake_request, 1'b1)
      apb(1'b1, ssr_pkg::INTERRUPT_CONTROL_OFF, 32'hc0);
      apb(1'b0, ssr_pkg::POWER_CONTROL_OFF, 32'h0);
      `CHK(r[1], 1'b1)
      `CHK(vector_branch, 1'b1)
      apb(1'b1, ssr_pkg::POWER_CONTROL_OFF, 32'h0);
      apb(1'b0, ssr_pkg::RECEIVE_BUFFER_OFF, 32'h0);
      `CHK(r[7:0], 8'h5a)
      `CHK(wake_request, 1'b0)
      $display("test sleep done");
      quiet_word(32'ha0, 32'h10);
      `CHK(r[1], 1'b0)
      quiet_word(32'h90, 32'h90);
      `CHK(r[1], 1'b0)
      apb(1'b0, 8'h1c, 32'h0);
      `CHK(r, 32'h0)
      $display("test refusals done");
      wrap_up();
   end
endmodule
